// *** include/mux_regs.svh ***
// constants for the channel mux control block: field positions, reset values, address pattern
// assumes inclusion by bare name from the package and the logic files
`ifndef MUX_REGS_SVH
`define MUX_REGS_SVH
// fixed upper address bits, value arbitrary for this block
`define MUX_ADDR_FIXED      4'hE
`define MUX_CTRL_RESET      8'h00
`define MUX_SEL_LSB_POS     0
`define MUX_SEL_MSB_POS     1
`define MUX_ENABLE_POS      2
`define MUX_UNUSED3_POS     3
`define MUX_IRQ_LO_POS      4
`define MUX_NUM_CHAN        4
`endif

// *** include/mux_pkg.sv ***
// types shared by the channel mux control logic
// assumes mux_regs.svh is on the include path
`include "mux_regs.svh"
package mux_pkg;
  // channel selection as stored
  typedef struct packed {
    logic       chan_enable_bit;
    logic       chan_sel_msb;
    logic       chan_sel_lsb;
  } mux_sel_t;
  // open-drain pin pair
  typedef struct packed {
    logic o;
    logic oe;
  } mux_od_t;
  // slave engine states
  typedef enum logic [5:0] {
    MUX_IDLE = 6'h01,
    MUX_ADDR = 6'h02,
    MUX_AACK = 6'h04,
    MUX_WR   = 6'h08,
    MUX_RD   = 6'h10,
    MUX_SACK = 6'h20
  } mux_state_t;
endpackage

// *** logic/mux_sync.sv ***
// two flip-flop synchroniser for a bundle of pin inputs
// assumes a free-running clk and an asynchronous high reset
module mux_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;  // first stage, read only by second
  // =========================
  // two-stage capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else if (ce) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// *** logic/mux_chan_dec.sv ***
// registered one-hot channel decoder
// assumes the selection is already committed at a stop condition
`include "mux_regs.svh"
module mux_chan_dec
  import mux_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // selection in, one-hot out
  input  mux_pkg::mux_sel_t            sel,
  output logic [`MUX_NUM_CHAN-1:0]     chan_on
);
  // decoding of the three low bits into at most one channel
  function automatic logic [`MUX_NUM_CHAN-1:0] dec(input mux_sel_t s);
    logic [`MUX_NUM_CHAN-1:0] r;
    r = '0;
    if (s.chan_enable_bit) begin
      r[{s.chan_sel_msb, s.chan_sel_lsb}] = 1'b1;
    end
    return r;
  endfunction
  // =========================
  // output register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_on <= '0;
    end else if (ce) begin
      chan_on <= dec(sel);
    end
  end
endmodule

// *** logic/mux_ctrl.sv ***
// I2C slave control of a one-of-four bus multiplexer with interrupt combine
// assumes scl/sda pins are oversampled by clk, far faster than the bus
// assumes the straps are static and the interrupt inputs are level signals
//
// Operation
// - low address bits from select pins
// - last address bit: one read, zero write
// - acknowledge each received addressed byte
// - every written byte stored, last remains
// - register both writable and readable
// - enable bit plus two-bit channel number
// - at most one channel connected
// - new selection connects only at stop
// - all bits zero after power-up
// - interrupt output low if any input low
// - interrupt detection independent of selection
// - bits four to seven show channel interrupts
// - read samples live interrupt inputs
// - all asserted interrupts shown independently
// - interrupt status and output never latch
// - interrupt inputs usable as plain inputs
`include "mux_regs.svh"
module mux_ctrl
  import mux_pkg::*;
(
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // upstream bus pins
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  // address select straps
  input  wire logic [2:0]          addr_select_pins,
  // channel interrupt inputs, active low
  input  wire logic                chan0_irq_in_n,
  input  wire logic                chan1_irq_in_n,
  input  wire logic                chan2_irq_in_n,
  input  wire logic                chan3_irq_in_n,
  // combined open-drain interrupt
  output logic                     irq_out,
  output logic                     irq_oe,
  // downstream switch enables, one per channel
  output logic [`MUX_NUM_CHAN-1:0] chan_connect
);
  import mux_pkg::*;

  // =========================
  // pin synchronisers
  logic [1:0]               bus_s;    // synced scl, sda
  logic [2:0]               addr_s;   // synced straps
  logic [`MUX_NUM_CHAN-1:0] irqn_s;   // synced interrupt inputs
  logic                     scl_s;
  logic                     sda_s;

  // bus lines reset to idle high, so the edge logic sees no false start
  mux_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  ({scl_in, sda_in}),
    .dout (bus_s)
  );

  // straps settle within two cycles of reset release
  mux_sync #(.W(3), .INIT(3'h0)) u_addr_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  (addr_select_pins),
    .dout (addr_s)
  );

  // interrupt lines reset to idle high, no request pending
  mux_sync #(.W(`MUX_NUM_CHAN), .INIT(4'hF)) u_irq_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  ({chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n}),
    .dout (irqn_s)
  );

  // split the synced bus pair
  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // =========================
  // bus edge and condition detect
  logic scl_q;   // previous scl
  logic sda_q;   // previous sda
  logic scl_rise;
  logic scl_fall;
  logic start_c; // start or repeated start
  logic stop_c;  // stop

  // previous-level registers for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle high, so no false edge follows reset
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      // one cycle back of the synced levels
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // edges and conditions from synced levels only
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // =========================
  // slave engine
  mux_state_t state_q;   // engine state
  logic [2:0] bit_q;     // bit counter within byte
  logic [7:0] shift_q;   // receive or transmit shift
  logic       rd_q;      // current transfer is a read
  logic       sda_lo_q;  // drive sda low
  logic       wr_pulse;  // byte completed in write
  logic [7:0] rx_byte;   // byte just completed
  logic       addr_hit;  // address matches
  logic [7:0] rd_value;  // value returned on read
  mux_sel_t   pend_q;    // written, not yet committed
  mux_sel_t   act_q;     // committed selection

  // current bit joined to the shift register
  assign rx_byte  = {shift_q[6:0], sda_s};
  // fixed upper pattern plus strap bits
  assign addr_hit = (rx_byte[7:4] == `MUX_ADDR_FIXED) &&
                    (rx_byte[3:1] == addr_s);
  // live inputs in upper bits, pending selection in lower bits
  assign rd_value = {~irqn_s, 1'b0, pend_q};
  // strobe at the eighth bit of a write byte
  assign wr_pulse = scl_rise && (state_q == MUX_WR) && (bit_q == 3'h7);

  // state, counter and shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // power-up: idle, bus released
      state_q  <= MUX_IDLE;
      bit_q    <= 3'h0;
      shift_q  <= 8'h00;
      rd_q     <= 1'b0;
      sda_lo_q <= 1'b0;
    end else if (ce) begin
      // a stop always returns to idle and frees sda
      if (stop_c) begin
        state_q  <= MUX_IDLE;
        sda_lo_q <= 1'b0;
      end else if (start_c) begin
        // address follows a start
        state_q  <= MUX_ADDR;
        bit_q    <= 3'h0;
        sda_lo_q <= 1'b0;
      end else begin
        // bit handling between conditions
        case (state_q)
          MUX_IDLE: begin
            // wait for a start, bus released
            sda_lo_q <= 1'b0;
          end
          MUX_ADDR: begin
            // address bits in on each rise, counter wraps after eight
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_q   <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                // address complete: ack only on a match
                if (addr_hit) begin
                  state_q <= MUX_AACK;
                  rd_q    <= rx_byte[0];
                end else begin
                  // not ours: stay quiet until the next start
                  state_q <= MUX_IDLE;
                end
              end
            end
          end
          MUX_AACK: begin
            // ack driven from falling edge through the ack pulse
            if (scl_fall && !sda_lo_q) begin
              sda_lo_q <= 1'b1;
            end else if (scl_fall && sda_lo_q) begin
              // ack clock over: hand over to read or write
              if (rd_q) begin
                // load the byte to return, first bit out now
                state_q  <= MUX_RD;
                shift_q  <= rd_value;
                sda_lo_q <= ~rd_value[7];
              end else begin
                // release sda so the master can send data
                state_q  <= MUX_WR;
                sda_lo_q <= 1'b0;
              end
              bit_q <= 3'h0;
            end
          end
          MUX_WR: begin
            // receive a data byte msb first
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_q   <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                state_q <= MUX_AACK;
              end
            end
          end
          MUX_RD: begin
            // next bit out on each clock fall
            if (scl_fall) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                // byte sent: release for the master's ack
                state_q  <= MUX_SACK;
                sda_lo_q <= 1'b0;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                sda_lo_q <= ~shift_q[6];
              end
            end
          end
          MUX_SACK: begin
            // master ack: send another fresh copy, nack: release
            if (scl_rise) begin
              state_q <= sda_s ? MUX_IDLE : MUX_SACK;
            end else if (scl_fall) begin
              // acked: resample the live inputs for the next byte
              state_q  <= MUX_RD;
              bit_q    <= 3'h0;
              shift_q  <= rd_value;
              sda_lo_q <= ~rd_value[7];
            end
          end
          default: begin
            // unknown code: recover to idle
            state_q  <= MUX_IDLE;
            sda_lo_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // =========================
  // control register: pending and committed selection
  // closing a switch mid-transfer could show a false start downstream
  // reset image of the whole register; only the selection bits are stored
  localparam logic [7:0] CTRL_RST = `MUX_CTRL_RESET;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // power-up: no selection, nothing pending
      pend_q <= mux_sel_t'(CTRL_RST[2:0]);
      act_q  <= mux_sel_t'(CTRL_RST[2:0]);
    end else if (ce) begin
      if (wr_pulse) begin
        // only low bits kept, later bytes overwrite
        pend_q <= rx_byte[`MUX_ENABLE_POS:`MUX_SEL_LSB_POS];
      end
      // commit the pending selection only at a stop
      if (stop_c) begin
        act_q <= pend_q;
      end
    end
  end

  // registered decode keeps the switch enables glitch free
  mux_chan_dec u_dec (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .sel     (act_q),
    .chan_on (chan_connect)
  );

  // =========================
  // pin drivers: registered open-drain outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // pins released during reset
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
      // pulled low only for an ack or a zero read bit
      sda_oe  <= sda_lo_q;
      irq_out <= 1'b0;
      // AND of inputs, live and unlatched, any selection
      irq_oe  <= ~(&irqn_s);
    end
  end
endmodule

// *** tb/mux_ctrl_properties.sv ***
// port checker for mux_ctrl
// assumes bind into mux_ctrl, one clock, reset high
`include "mux_regs.svh"
module mux_ctrl_properties (
  // clock and reset
  input wire logic clk, rst, ce,
  // bus pins and straps
  input wire logic scl_in, sda_in, sda_out, sda_oe,
  input wire logic [2:0] addr_select_pins,
  // interrupt pins
  input wire logic chan0_irq_in_n, chan1_irq_in_n, chan2_irq_in_n, chan3_irq_in_n,
  input wire logic irq_out, irq_oe,
  // channel switches
  input wire logic [`MUX_NUM_CHAN-1:0] chan_connect
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       all_hi;    // no channel asserted
  logic       sda_q;     // data pin last cycle
  logic [3:0] since_p_q; // cycles since a stop, saturating
  assign all_hi = &{chan0_irq_in_n, chan1_irq_in_n, chan2_irq_in_n, chan3_irq_in_n};
  // ==========
  // stop tracker: data rises while clock high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_q <= 1'b1;
      since_p_q <= 4'hF;
    end else begin
      sda_q <= sda_in;
      if (scl_in && sda_in && !sda_q) since_p_q <= 4'h0;
      else if (since_p_q != 4'hF) since_p_q <= since_p_q + 4'h1;
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence scl_hi2; scl_in [*2]; endsequence
  sequence irq_on5; !all_hi [*5]; endsequence
  sequence irq_off5; all_hi [*5]; endsequence
  a_one_channel: assert property ($onehot0(chan_connect)) else $error("two channels on");
  a_conn_at_stop: assert property ($changed(chan_connect) |-> since_p_q < 4'hC)
    else $error("switch moved without stop");
  a_ack_steady: assert property (scl_hi2 |-> $stable(sda_oe)) else $error("data moved");
  a_ack_in_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("drive began in clock high");
  a_sda_drive: assert property (sda_oe |-> !sda_out) else $error("data driven high");
  a_irq_drive: assert property (irq_oe |-> !irq_out) else $error("irq driven high");
  a_irq_follows: assert property (irq_on5 |-> irq_oe) else $error("irq missed");
  a_irq_no_latch: assert property (irq_off5 |-> !irq_oe) else $error("irq latched");
  a_reset_clear:
    assert property (disable iff (1'b0) rst |-> !sda_oe && !irq_oe && chan_connect == '0)
    else $error("reset state wrong");
endmodule
bind mux_ctrl mux_ctrl_properties mux_ctrl_properties_i (
  .clk(clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_select_pins(addr_select_pins), .chan0_irq_in_n(chan0_irq_in_n),
  .chan1_irq_in_n(chan1_irq_in_n), .chan2_irq_in_n(chan2_irq_in_n),
  .chan3_irq_in_n(chan3_irq_in_n), .irq_out(irq_out), .irq_oe(irq_oe),
  .chan_connect(chan_connect));

// *** tb/mux_i2c_master.sv ***
// behavioural upstream bus master, timed in bench clock cycles
// assumes the bench resolves the data wire with a pull-up
module mux_i2c_master (
  // bench clock
  input wire logic clk,
  // bus pins
  input wire logic sda,
  output logic     scl = 1'b1,
  output logic     sda_low = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // wait whole cycles, changes land off the sampling edge
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit: data set while clock low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    w(5);
    scl = 1'b1;
    w(5);
    r = sda;
    w(5);
    scl = 1'b0;
    w(5);
  endtask
  // start: data falls while clock high
  task automatic start();
    sda_low = 1'b1;
    w(10);
    scl = 1'b0;
    w(5);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda_low = 1'b0;
    w(15);
  endtask
  // byte out msb first, ninth bit released; ack means data low
  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, r);
    k = !r;
  endtask
endmodule

// *** tb/mux_ctrl_tb.sv ***
// bench for mux_ctrl driven by a behavioural bus master
// assumes the checker is bound into mux_ctrl
`include "mux_regs.svh"
module mux_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // pins
  logic clk = 1'b0, rst = 1'b0, ce = 1'b1, scl, low, sda_oe, irq_oe;
  logic [2:0] strap;
  logic [3:0] irq_n = 4'hF, conn;
  wire        sda = !(low | sda_oe); // pull-up, any party pulls low
  // scoreboard and stimulus
  logic [31:0] seed = 32'hE8FF455D, r;
  logic [7:0]  exp_q[$], res, q;
  logic [2:0]  sel = 3'h0; // last accepted selection
  logic        k;
  event        res_ev;
  int          miscompares = 0, tests_run = 0;
  always #50 clk = ~clk;
  mux_ctrl mux_ctrl_i (.clk(clk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .addr_select_pins(strap), .chan0_irq_in_n(irq_n[0]),
    .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]),
    .irq_out(), .irq_oe(irq_oe), .chan_connect(conn));
  mux_i2c_master mux_i2c_master_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(low));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] dec(input logic [2:0] s);
    return s[2] ? 8'h01 << s[1:0] : 8'h00;
  endfunction
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  always @(res_ev) cmp(exp_q.pop_front(), res);
  task automatic note(input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    res = g;
    ->res_ev;
    #1;
  endtask
  // one transfer: address, then a read byte or one or two write bytes
  task automatic xfer(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d0,
                      input logic two);
    logic ok;
    ok = (a[7:1] == {`MUX_ADDR_FIXED, strap});
    mux_i2c_master_i.start();
    mux_i2c_master_i.xb(a, q, k);
    note({7'h0, ok}, {7'h0, k});
    if (ok && a[0]) begin
      mux_i2c_master_i.xb(8'hFF, q, k);
      note({~irq_n, 1'b0, sel}, q);
    end
    if (ok && !a[0]) begin
      if (two) mux_i2c_master_i.xb(d1, q, k);
      if (two) note(8'h01, {7'h0, k});
      mux_i2c_master_i.xb(d0, q, k);
      note(8'h01, {7'h0, k});
      note(dec(sel), {4'h0, conn});
    end
    mux_i2c_master_i.stop();
    if (ok && !a[0]) sel = d0[2:0];
    note(dec(sel), {4'h0, conn});
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin
    // raise reset once every process waits, so its edge clears all state
    #1 rst = 1'b1;
    r = xs();
    strap = r[2:0];
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    note(8'h00, {4'h0, conn});
    xfer({`MUX_ADDR_FIXED, strap, 1'b1}, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      @(negedge clk) irq_n = r[3:0];
      xfer({`MUX_ADDR_FIXED, strap, 1'b0}, r[15:8], {r[23:19], 3'(i)}, r[24]);
      note({7'h0, ~&irq_n}, {7'h0, irq_oe});
      xfer({`MUX_ADDR_FIXED, strap, 1'b1}, 8'h00, 8'h00, 1'b0);
    end
    xfer({`MUX_ADDR_FIXED, ~strap, 1'b0}, 8'h00, 8'h07, 1'b0);
    xfer({4'h1, strap, 1'b0}, 8'h00, 8'h07, 1'b0);
    give_verdict();
  end
endmodule
